/* src/pserst_map.svh */
// Register offsets, field positions, reset values and timing counts for the
// push-button, identification and status register group.
// Assumes only that it is included by its bare name by the design files.
`ifndef PSERST_MAP_SVH
`define PSERST_MAP_SVH

// ============================================================================
// Register offsets.
`define PSERST_OFF_PUSH        8'h1a
`define PSERST_OFF_ID          8'h1b
`define PSERST_OFF_STATUS      8'h1c

// ============================================================================
// Push-button field positions.
`define PSERST_BIT_CLEAR_ALL   7
`define PSERST_BIT_RELEASE     6
`define PSERST_BIT_UNUSED      5
`define PSERST_BIT_RESET_ALL   4
`define PSERST_CHAN_RESET_HI   3
`define PSERST_CHAN_RESET_LO   0

// ============================================================================
// Identification and status layout and reset values.
`define PSERST_ID_MAKER_HI     7
`define PSERST_ID_MAKER_LO     3
`define PSERST_ID_REV_HI       2
`define PSERST_ID_REV_LO       0
// Arbitrary neutral identification values.
`define PSERST_ID_MAKER_RST    5'h13
`define PSERST_ID_REV_RST      3'h2
`define PSERST_AC_RST          4'h0
`define PSERST_CC_RST          2'h0
`define PSERST_READ_ZERO       8'h00

// ============================================================================
// Timing.
`define PSERST_CLK_MHZ         200
`define PSERST_CLR_TIME_MS     5
`define PSERST_CLR_CYCLES      (`PSERST_CLR_TIME_MS * 1000 * `PSERST_CLK_MHZ)
`define PSERST_CNT_W           20

`endif

/* src/pserst_pkg.sv */
// Types shared by the register group: request, engine and control carriers,
// connection-check codes and the state records of each module.
// Assumes the map header is available on the include path.
`include "pserst_map.svh"

package pserst_pkg;

    // ========================================================================
    // Connection-check result codes.
    typedef enum logic [1:0] {
        CC_UNKNOWN = 2'h0,
        CC_SINGLE  = 2'h1,
        CC_DUAL    = 2'h2,
        CC_RSVD    = 2'h3
    } pserst_cc_type;

    // ========================================================================
    // Register access from the serial front end.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pserst_req_type;

    // Status and requests from the detection and classification engine.
    typedef struct packed {
        logic [3:0]    acDone;
        logic [3:0]    acSupport;
        logic [1:0]    ccReq;
        logic [1:0]    ccDone;
        pserst_cc_type ccResA;
        pserst_cc_type ccResB;
        logic [3:0]    detValid;
        logic [3:0]    turnOn;
        logic [1:0]    fourPair;
        logic          irqPending;
    } pserst_eng_type;

    // One-cycle commands towards the rest of the controller.
    typedef struct packed {
        logic       clearAllEvents;
        logic       resetGroup;
        logic [3:0] chanOff;
        logic [3:0] cooldownAbort;
        logic [3:0] policeOnes;
        logic [1:0] ccStart;
        logic [1:0] detEventSet;
        logic [3:0] acMeasStart;
    } pserst_ctl_type;

    // ========================================================================
    // Module state records.
    typedef struct packed {
        pserst_ctl_type ctl;
        logic [7:0]     rdData;
        logic           rdValid;
        logic           intN;
        logic           pinReleased;
        logic [4:0]     makerCode;
        logic [2:0]     revision;
        logic [3:0]     acBits;
        pserst_cc_type  ccA;
        pserst_cc_type  ccB;
        logic [1:0]     pendDet;
        logic [3:0]     clrStart;
    } pserst_state_type;

    typedef struct packed {
        logic [`PSERST_CNT_W-1:0] count;
        logic                     busy;
    } pserst_clr_type;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] level;
    } pserst_sync_type;

endpackage : pserst_pkg

/* src/pserst_sync.sv */
// Three-stage synchroniser for the two supply undervoltage pins.
// Assumes asynchronous pin levels; a change counts once stages two and three
// agree, so a single metastable sample never reaches the level output.
`timescale 1ns/100ps
`default_nettype none

module pserst_sync
    import pserst_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic [1:0] pinIn,
    output logic      [1:0] level
);

    pserst_sync_type s;
    pserst_sync_type next_s;

    // ========================================================================
    // Stage chain.
    always_comb begin
        next_s    = s;
        next_s.s1 = pinIn;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < 2; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.level[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign level = s.level;

endmodule : pserst_sync

`default_nettype wire

/* src/pserst_chan_clear.sv */
// Per-channel clear window: after a channel reset the affected registers may
// take this long to settle, so busy stays high for the whole window.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "pserst_map.svh"

module pserst_chan_clear
    import pserst_pkg::*;
#(
    parameter int CLR_CYCLES = `PSERST_CLR_CYCLES
)
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    input  wire logic start,
    output logic      busy
);

    pserst_clr_type s;
    pserst_clr_type next_s;

    // ========================================================================
    // Window counter; a new start restarts the window.
    always_comb begin
        next_s = s;
        if (start) begin
            next_s.count = `PSERST_CNT_W'(CLR_CYCLES - 1);
            next_s.busy  = 1'b1;
        end else if (s.busy) begin
            if (s.count == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.count = s.count - `PSERST_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign busy = s.busy;

    property p_clear_window;
        @(posedge ref_clk) disable iff (sys_rst)
        (start && clkEn) |=> busy;
    endproperty
    a_clear_window: assert property (p_clear_window)
        else $error("Clear window did not open after channel reset.");

endmodule : pserst_chan_clear

`default_nettype wire

/* src/pserst_regs.sv */
// Push-button control, identification and connection-check / auto-class
// status registers for one group of four channels.
// Assumes a serial front end delivering decoded command accesses on the same
// clock, and an engine reporting classification and check results.
`timescale 1ns/100ps
`default_nettype none
`include "pserst_map.svh"

module pserst_regs
    import pserst_pkg::*;
#(
    parameter int CLR_CYCLES = `PSERST_CLR_CYCLES
)
(
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    input  wire logic           clkEn,
    input  wire pserst_req_type req,
    input  wire pserst_eng_type eng,
    input  wire logic [1:0]     supplyUvPin,
    output logic [7:0]          rdData,
    output logic                rdValid,
    output logic                intN,
    output pserst_ctl_type      ctl,
    output logic [3:0]          chanClearBusy,
    output logic [1:0]          supplyUv
);

    pserst_state_type s;
    pserst_state_type next_s;

    logic             pushWr;
    logic [3:0]       chanReset;
    logic [1:0]       portReset;
    logic [1:0]       ccAccept;
    logic             nextPending;

    // ========================================================================
    // Access decode.
    assign pushWr = req.wr && (req.addr == `PSERST_OFF_PUSH);

    // The two channels of a four-pair port share one turn-off, so a request
    // on either one is widened here before any clearing happens.
    always_comb begin
        chanReset = 4'h0;
        if (pushWr) begin
            chanReset = req.wdata[`PSERST_CHAN_RESET_HI:`PSERST_CHAN_RESET_LO];
        end
        if (eng.fourPair[0] && (chanReset[1:0] != 2'h0)) begin
            chanReset[1:0] = 2'h3;
        end
        if (eng.fourPair[1] && (chanReset[3:2] != 2'h0)) begin
            chanReset[3:2] = 2'h3;
        end
        portReset[0] = chanReset[0] || chanReset[1];
        portReset[1] = chanReset[2] || chanReset[3];
    end

    // A result arriving for a port that is not four-pair is dropped.
    assign ccAccept = eng.ccDone & eng.fourPair;

    // ========================================================================
    // Next state.
    always_comb begin
        next_s         = s;
        next_s.rdValid = 1'b0;
        next_s.ctl     = '0;
        nextPending    = s.pinReleased;

        // Read path.
        if (req.rd) begin
            next_s.rdValid = 1'b1;
            unique case (req.addr)
                `PSERST_OFF_ID: begin
                    next_s.rdData = {s.makerCode, s.revision};
                end
                `PSERST_OFF_STATUS: begin
                    next_s.rdData = {s.acBits, s.ccB, s.ccA};
                end
                default: begin
                    next_s.rdData = `PSERST_READ_ZERO;
                end
            endcase
        end

        // Identification is writable and returns to its defaults on reset-all.
        if (req.wr && (req.addr == `PSERST_OFF_ID)) begin
            next_s.makerCode =
                req.wdata[`PSERST_ID_MAKER_HI:`PSERST_ID_MAKER_LO];
            next_s.revision  =
                req.wdata[`PSERST_ID_REV_HI:`PSERST_ID_REV_LO];
        end

        // Push-button actions; bit 5 has no decode and so no effect.
        if (pushWr && req.wdata[`PSERST_BIT_CLEAR_ALL]) begin
            next_s.ctl.clearAllEvents = 1'b1;
            nextPending               = 1'b1;
        end
        if (pushWr && req.wdata[`PSERST_BIT_RELEASE]) begin
            nextPending = 1'b1;
        end
        if (pushWr && req.wdata[`PSERST_BIT_RESET_ALL]) begin
            // Only this group's state is restored; supply levels are
            // tracked separately and never reset here.
            next_s.ctl.resetGroup = 1'b1;
            next_s.makerCode      = `PSERST_ID_MAKER_RST;
            next_s.revision       = `PSERST_ID_REV_RST;
            next_s.acBits         = `PSERST_AC_RST;
            next_s.ccA            = CC_UNKNOWN;
            next_s.ccB            = CC_UNKNOWN;
            next_s.pendDet        = 2'h0;
        end

        // Channel turn-off and its side effects.
        next_s.ctl.chanOff       = chanReset;
        next_s.ctl.cooldownAbort = chanReset;
        next_s.ctl.policeOnes    = chanReset;
        next_s.clrStart          = chanReset;
        next_s.acBits            = next_s.acBits & ~chanReset;
        if (portReset[0]) begin
            next_s.ccA = CC_UNKNOWN;
        end
        if (portReset[1]) begin
            next_s.ccB = CC_UNKNOWN;
        end

        // Engine results are applied after the clears so that a result
        // landing in the same cycle as a clear is kept.
        if (ccAccept[0]) begin
            next_s.ccA = eng.ccResA;
        end
        if (ccAccept[1]) begin
            next_s.ccB = eng.ccResB;
        end
        for (int i = 0; i < 4; i++) begin
            if (eng.acDone[i]) begin
                next_s.acBits[i] = eng.acSupport[i];
            end
        end
        // A single-signature four-pair load is classified on one channel,
        // so its result is mirrored onto the partner channel.
        for (int p = 0; p < 2; p++) begin
            if (eng.fourPair[p] && (next_s.ccA == CC_SINGLE || p == 1)
                && ((p == 0) || next_s.ccB == CC_SINGLE)
                && (eng.acDone[2*p] || eng.acDone[2*p+1])) begin
                next_s.acBits[2*p]   = eng.acDone[2*p] ?
                    eng.acSupport[2*p] : eng.acSupport[2*p+1];
                next_s.acBits[2*p+1] = next_s.acBits[2*p];
            end
        end

        // Detection events follow one cycle after the check field is written.
        next_s.pendDet         = ccAccept;
        next_s.ctl.detEventSet = s.pendDet;

        // Checks start only on four-pair ports with a valid detection.
        next_s.ctl.ccStart[0] = eng.ccReq[0] && eng.fourPair[0]
            && (eng.detValid[1:0] != 2'h0);
        next_s.ctl.ccStart[1] = eng.ccReq[1] && eng.fourPair[1]
            && (eng.detValid[3:2] != 2'h0);

        // Measurement request per channel; results land in per-channel
        // registers owned by the measurement block.
        next_s.ctl.acMeasStart = eng.turnOn & s.acBits;

        // Interrupt pin. The release holds until nothing is pending.
        if (s.pinReleased && !eng.irqPending) begin
            nextPending = 1'b0;
        end
        if (pushWr && (req.wdata[`PSERST_BIT_CLEAR_ALL]
                       || req.wdata[`PSERST_BIT_RELEASE])) begin
            nextPending = 1'b1;
        end
        next_s.pinReleased = nextPending;
        next_s.intN        = !(eng.irqPending && !nextPending);
    end

    // ========================================================================
    // State register.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s           <= '0;
            s.intN      <= 1'b1;
            s.makerCode <= `PSERST_ID_MAKER_RST;
            s.revision  <= `PSERST_ID_REV_RST;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign rdData  = s.rdData;
    assign rdValid = s.rdValid;
    assign intN    = s.intN;
    assign ctl     = s.ctl;

    // ========================================================================
    // Per-channel clear windows and supply tracking.
    for (genvar i = 0; i < 4; i++) begin : g_clear
        pserst_chan_clear #(
            .CLR_CYCLES (CLR_CYCLES)
        ) u_clear (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .clkEn   (clkEn),
            .start   (s.clrStart[i]),
            .busy    (chanClearBusy[i])
        );
    end

    pserst_sync u_supply (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .pinIn   (supplyUvPin),
        .level   (supplyUv)
    );

    // ========================================================================
    // Checks.
    property p_push_reads_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && req.rd && req.addr == `PSERST_OFF_PUSH)
            |=> (rdValid && rdData == 8'h00);
    endproperty
    a_push_reads_zero: assert property (p_push_reads_zero)
        else $error("Push-button read did not return zero.");

    property p_clear_all_releases;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && pushWr && req.wdata[7])
            |=> (intN && ctl.clearAllEvents);
    endproperty
    a_clear_all_releases: assert property (p_clear_all_releases)
        else $error("Clear-all did not release pin and clear events.");

    property p_release_pin;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && pushWr && req.wdata[6] && !req.wdata[7])
            |=> (intN && !ctl.clearAllEvents);
    endproperty
    a_release_pin: assert property (p_release_pin)
        else $error("Pin release failed or cleared events.");

    property p_released_stays_high;
        @(posedge ref_clk) disable iff (sys_rst)
        s.pinReleased |-> intN;
    endproperty
    a_released_stays_high: assert property (p_released_stays_high)
        else $error("Interrupt pin asserted while released.");

    property p_reset_all_id;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && pushWr && req.wdata[4])
            |=> (s.makerCode == `PSERST_ID_MAKER_RST && ctl.resetGroup);
    endproperty
    a_reset_all_id: assert property (p_reset_all_id)
        else $error("Reset-all did not restore identification.");

    property p_chan_off;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && pushWr && req.wdata[2] && eng.acDone[3:2] == 2'h0)
            |=> (ctl.chanOff[2] && ctl.cooldownAbort[2] && !s.acBits[2]);
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("Channel reset did not turn channel off.");

    property p_four_pair_both;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && pushWr && req.wdata[1] && eng.fourPair[0])
            |=> (ctl.chanOff[0] && ctl.chanOff[1]);
    endproperty
    a_four_pair_both: assert property (p_four_pair_both)
        else $error("Four-pair reset did not reset both channels.");

    property p_check_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        (ctl.ccStart[0] && $past(clkEn)) |-> $past(eng.fourPair[0]);
    endproperty
    a_check_gate: assert property (p_check_gate)
        else $error("Connection check started on two-pair port.");

    property p_check_before_event;
        @(posedge ref_clk) disable iff (sys_rst)
        (clkEn && ccAccept[1] && !(pushWr && req.wdata[4])) ##1 clkEn
            |=> (ctl.detEventSet[1] && $past(s.ccB) == $past(eng.ccResB, 2));
    endproperty
    a_check_before_event: assert property (p_check_before_event)
        else $error("Detection event not after check result update.");

endmodule : pserst_regs

`default_nettype wire

/* verif/pserst_host.sv */
// Host model: issues single-byte register accesses, one cycle each.
// Assumes ref_clk is free running; requests change on the falling edge.
`timescale 1ns/100ps
`default_nettype none

module pserst_host
    import pserst_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] rdData,
    output var pserst_req_type req
);
    // ========================================================================
    // Bus cycles.
    initial req = '0;

    // Channels are never re-enabled here, so writes do not wait out the clear window.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk);
        req <= '0;
        d = rdData;
    endtask : rd
endmodule : pserst_host
`default_nettype wire

/* verif/tb.sv */
// Testbench for the push-button, identification and status registers.
// Assumes the host model drives requests; the bench drives the engine side.
`timescale 1ns/100ps
`default_nettype none

module tb
    import pserst_pkg::*;
;
    localparam int ClrCycles = 16;
    logic           ref_clk = 1'b0;
    logic           sys_rst = 1'b1;
    logic           clkEn = 1'b1;
    pserst_req_type req;
    pserst_eng_type eng = '0;
    logic [1:0]     supplyUvPin = 2'h0;
    logic [7:0]     rdData;
    logic           rdValid;
    logic           intN;
    pserst_ctl_type ctl;
    logic [3:0]     chanClearBusy;
    logic [1:0]     supplyUv;
    logic [7:0]     d;
    int             fails = 0;
    int             comparisons = 0;

    always #2.5 ref_clk = ~ref_clk;

    pserst_host host_u (.ref_clk(ref_clk), .rdData(rdData), .req(req));
    pserst_regs #(.CLR_CYCLES(ClrCycles)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .req(req),
        .eng(eng), .supplyUvPin(supplyUvPin), .rdData(rdData),
        .rdValid(rdValid), .intN(intN), .ctl(ctl),
        .chanClearBusy(chanClearBusy), .supplyUv(supplyUv));

    // ========================================================================
    // Checking and closing.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // ========================================================================
    // Scenarios.
    task automatic t_ident();
        host_u.rd(8'h1b, d);
        check(d, 8'h9a);
        check({7'h0, rdValid}, 8'h01);
        host_u.rd(8'h1a, d);
        check(d, 8'h00);
        host_u.rd(8'h55, d);
        check(d, 8'h00);
        $display("ident done");
    endtask : t_ident

    task automatic t_chan();
        host_u.wr(8'h1a, 8'h01);
        check({4'h0, ctl.chanOff}, 8'h01);
        check({4'h0, ctl.cooldownAbort}, 8'h01);
        check({4'h0, ctl.policeOnes}, 8'h01);
        @(negedge ref_clk);
        check({4'h0, chanClearBusy}, 8'h01);
        repeat (ClrCycles) @(negedge ref_clk);
        check({4'h0, chanClearBusy}, 8'h00);
        eng.fourPair = 2'h1;
        host_u.wr(8'h1a, 8'h02);
        check({4'h0, ctl.chanOff}, 8'h03);
        host_u.wr(8'h1a, 8'h20);
        check({4'h0, ctl.chanOff}, 8'h00);
        check({7'h0, ctl.resetGroup}, 8'h00);
        clkEn = 1'b0;
        host_u.wr(8'h1a, 8'h04);
        check({4'h0, ctl.chanOff}, 8'h00);
        clkEn = 1'b1;
        @(negedge ref_clk);
        check({4'h0, ctl.chanOff}, 8'h00);
        $display("chan done");
    endtask : t_chan

    task automatic t_irq();
        eng.irqPending = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({7'h0, intN}, 8'h00);
        host_u.wr(8'h1a, 8'h40);
        check({7'h0, intN}, 8'h01);
        check({7'h0, ctl.clearAllEvents}, 8'h00);
        repeat (3) @(negedge ref_clk);
        check({7'h0, intN}, 8'h01);
        eng.irqPending = 1'b0;
        repeat (2) @(negedge ref_clk);
        eng.irqPending = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({7'h0, intN}, 8'h00);
        host_u.wr(8'h1a, 8'h80);
        check({7'h0, ctl.clearAllEvents}, 8'h01);
        check({7'h0, intN}, 8'h01);
        eng.irqPending = 1'b0;
        $display("irq done");
    endtask : t_irq

    task automatic t_status();
        logic [1:0] codes [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
        eng.detValid = 4'h1;
        eng.ccReq = 2'h1;
        @(negedge ref_clk);
        eng.ccReq = 2'h0;
        check({6'h0, ctl.ccStart}, 8'h01);
        eng.detValid = 4'h0;
        eng.ccReq = 2'h1;
        @(negedge ref_clk);
        eng.ccReq = 2'h0;
        check({6'h0, ctl.ccStart}, 8'h00);
        foreach (codes[i]) begin
            eng.ccDone = 2'h1;
            eng.ccResA = pserst_cc_type'(codes[i]);
            @(negedge ref_clk);
            eng.ccDone = 2'h0;
            check({6'h0, ctl.detEventSet}, 8'h00);
            @(negedge ref_clk);
            check({6'h0, ctl.detEventSet}, 8'h01);
            host_u.rd(8'h1c, d);
            check(d, {6'h0, codes[i]});
        end
        eng.acDone = 4'h5;
        eng.acSupport = 4'h5;
        @(negedge ref_clk);
        eng.acDone = 4'h0;
        eng.turnOn = 4'h1;
        @(negedge ref_clk);
        eng.turnOn = 4'h0;
        check({4'h0, ctl.acMeasStart}, 8'h01);
        host_u.rd(8'h1c, d);
        check(d, 8'h71);
        host_u.wr(8'h1c, 8'hff);
        host_u.rd(8'h1c, d);
        check(d, 8'h71);
        eng.fourPair = 2'h3;
        eng.ccDone = 2'h2;
        eng.ccResB = CC_DUAL;
        @(negedge ref_clk);
        eng.ccDone = 2'h0;
        @(negedge ref_clk);
        check({6'h0, ctl.detEventSet}, 8'h02);
        host_u.rd(8'h1c, d);
        check(d, 8'h79);
        host_u.wr(8'h1b, 8'h55);
        host_u.rd(8'h1b, d);
        check(d, 8'h55);
        supplyUvPin = 2'h3;
        host_u.wr(8'h1a, 8'h10);
        check({7'h0, ctl.resetGroup}, 8'h01);
        repeat (4) @(negedge ref_clk);
        host_u.rd(8'h1c, d);
        check(d, 8'h00);
        check({6'h0, supplyUv}, 8'h03);
        host_u.rd(8'h1b, d);
        check(d, 8'h9a);
        $display("status done");
    endtask : t_status

    // ========================================================================
    // Main sequence and watchdog.
    initial begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_ident();
        t_chan();
        t_irq();
        t_status();
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
